/* design/smi_regs.vh */
// constants for the shift / copy / indirect-load execution datapath
// assumes a 32-bit AXI4-Lite slave with byte addresses in the low 8 bits
`ifndef SMI_REGS_VH
`define SMI_REGS_VH

// register byte offsets
`define SMI_ADDR_CTRL      8'h00
`define SMI_ADDR_STATUS    8'h04
`define SMI_ADDR_PTR0      8'h08
`define SMI_ADDR_PTR1      8'h0C
`define SMI_ADDR_COUNT     8'h10

// field positions
`define SMI_CTRL_EN_BIT    0
`define SMI_STAT_ZERO_BIT  8
`define SMI_STAT_CARRY_BIT 9

// reset values
`define SMI_CTRL_RESET     1'b0
`define SMI_ACC_RESET      8'h00
`define SMI_PTR_RESET      16'h0000
`define SMI_COUNT_RESET    16'h0000

// operation selects from the decoder
`define SMI_OP_NONE        2'b00
`define SMI_OP_SHIFT       2'b01
`define SMI_OP_COPY        2'b10
`define SMI_OP_INDIRECT    2'b11

// pointer update codes
`define SMI_UPD_PREINC     2'b00
`define SMI_UPD_PREDEC     2'b01
`define SMI_UPD_POSTINC    2'b10
`define SMI_UPD_POSTDEC    2'b11

// file addresses of the two indirect window registers
`define SMI_WIN0_ADDR      7'h00
`define SMI_WIN1_ADDR      7'h01

// bus responses
`define SMI_RESP_OKAY      2'b00
`define SMI_RESP_DECERR    2'b11

// every operation completes in this many clock cycles
`define SMI_OP_CYCLES      1

`endif

/* design/smi_ptr.v */
// one 16-bit indirect pointer with wrap-around step and software load
// a step takes priority over a same-cycle software load
`timescale 1ns/1ps
`include "smi_regs.vh"

module smi_ptr
(
   input  wire        i_clock,
   input  wire        i_nrst,
   input  wire        i_ce,
   input  wire        i_step,
   input  wire        i_down,
   input  wire        i_sw_we,
   input  wire [1:0]  i_sw_strb,
   input  wire [15:0] i_sw_data,
   output wire [15:0] o_ptr
);

   reg  [15:0] ptr_reg;
   reg  [15:0] ptr_next;

   always @*
   begin
      ptr_next = ptr_reg;
      if (i_step)
      begin
         // plain 16-bit add keeps the modulo 65536 wrap
         if (i_down)
            ptr_next = ptr_reg - 16'h0001;
         else
            ptr_next = ptr_reg + 16'h0001;
      end
      else if (i_sw_we)
      begin
         if (i_sw_strb[0])
            ptr_next[7:0] = i_sw_data[7:0];
         if (i_sw_strb[1])
            ptr_next[15:8] = i_sw_data[15:8];
      end
   end

   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         ptr_reg <= `SMI_PTR_RESET;
      else if (i_ce)
         ptr_reg <= ptr_next;
   end

   assign o_ptr = ptr_reg;

endmodule // smi_ptr

/* design/smi_exec.v */
// execution datapath: right shift, file copy and indirect load, AXI4-Lite control
// assumes an asynchronous-read register file whose write lands at the clock edge
//
// Behaviour
// - shift right result: zero into bit 7, source bits 7..1 into 6..0.
// - shift loads carry from source bit 0 and zero flag from result.
// - shift destination select 0 writes accumulator, 1 writes file register.
// - file operand is a 7-bit address 0..127; destination select is one bit.
// - copy moves file register to accumulator (0) or back to itself (1).
// - copy updates zero flag from moved value for both destinations.
// - indirect load: one-bit pointer select, two-bit update code, offset -32..31.
// - update codes: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - address is pointer+1, pointer-1, pointer, or pointer plus signed offset.
// - pointer afterwards +1 for increments, -1 for decrements, unchanged relative.
// - indirect load puts addressed register in accumulator and sets zero flag.
// - window register access is redirected to the address in its pointer (shift and copy only; an indirect load is not redirected).
// - pointers span 16 bits and wrap modulo 65536.
// - copy takes one program word and completes in one cycle.
// - pointer stepping leaves all status flags untouched.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "smi_regs.vh"

module smi_exec
(
   input  wire        i_clock,
   input  wire        i_nrst,
   input  wire        i_ce,
   // decoder side
   input  wire        i_op_valid,
   input  wire [1:0]  i_op_sel,
   input  wire [6:0]  i_file_addr,
   input  wire        i_dest_sel,
   input  wire        i_ptr_sel,
   input  wire        i_rel_mode,
   input  wire [1:0]  i_update_code,
   input  wire [5:0]  i_rel_offset,
   output wire        o_op_ready,
   // register file side
   output wire [15:0] o_rf_raddr,
   input  wire [7:0]  i_rf_rdata,
   output wire        o_rf_we,
   output wire [15:0] o_rf_waddr,
   output wire [7:0]  o_rf_wdata,
   // core state
   output wire [7:0]  o_accum,
   output wire        o_zero,
   output wire        o_carry,
   output wire [15:0] o_ptr0,
   output wire [15:0] o_ptr1,
   // AXI4-Lite slave
   input  wire [7:0]  i_s_axi_awaddr,
   input  wire        i_s_axi_awvalid,
   output wire        o_s_axi_awready,
   input  wire [31:0] i_s_axi_wdata,
   input  wire [3:0]  i_s_axi_wstrb,
   input  wire        i_s_axi_wvalid,
   output wire        o_s_axi_wready,
   output wire [1:0]  o_s_axi_bresp,
   output wire        o_s_axi_bvalid,
   input  wire        i_s_axi_bready,
   input  wire [7:0]  i_s_axi_araddr,
   input  wire        i_s_axi_arvalid,
   output wire        o_s_axi_arready,
   output wire [31:0] o_s_axi_rdata,
   output wire [1:0]  o_s_axi_rresp,
   output wire        o_s_axi_rvalid,
   input  wire        i_s_axi_rready
);

   // core state
   reg  [7:0]  acc_reg;
   reg         zero_reg;
   reg         carry_reg;
   reg         rf_we_reg;
   reg  [15:0] rf_waddr_reg;
   reg  [7:0]  rf_wdata_reg;
   reg         en_reg;
   reg  [15:0] count_reg;

   // bus state
   reg         aw_got_reg;
   reg         w_got_reg;
   reg  [7:0]  awaddr_reg;
   reg  [31:0] wdata_reg;
   reg  [3:0]  wstrb_reg;
   reg         bvalid_reg;
   reg  [1:0]  bresp_reg;
   reg         rvalid_reg;
   reg  [31:0] rdata_reg;
   reg  [1:0]  rresp_reg;

   wire [15:0] ptr0;
   wire [15:0] ptr1;

   // operation decode
   wire        op_fire;
   wire        is_shift;
   wire        is_copy;
   wire        is_ind;
   wire        win0_hit;
   wire        win1_hit;
   wire [15:0] direct_addr;
   wire [15:0] sel_ptr;
   wire [15:0] off_ext;
   reg  [15:0] ind_addr;
   wire [15:0] read_addr;
   wire [7:0]  read_data;
   wire [7:0]  result;
   wire        to_acc;
   wire        step;
   wire        step_down;

   assign o_op_ready = en_reg;
   assign op_fire    = i_ce & en_reg & i_op_valid & (i_op_sel != `SMI_OP_NONE);
   assign is_shift   = (i_op_sel == `SMI_OP_SHIFT);
   assign is_copy    = (i_op_sel == `SMI_OP_COPY);
   assign is_ind     = (i_op_sel == `SMI_OP_INDIRECT);

   // window registers hold no data of their own
   assign win0_hit    = (i_file_addr == `SMI_WIN0_ADDR);
   assign win1_hit    = (i_file_addr == `SMI_WIN1_ADDR);
   assign direct_addr = win0_hit ? ptr0 :
                        win1_hit ? ptr1 :
                        {9'h000, i_file_addr};

   assign sel_ptr = i_ptr_sel ? ptr1 : ptr0;
   assign off_ext = {{10{i_rel_offset[5]}}, i_rel_offset};

   always @*
   begin
      ind_addr = sel_ptr;
      if (i_rel_mode)
         ind_addr = sel_ptr + off_ext;
      else
      begin
         case (i_update_code)
            `SMI_UPD_PREINC:  ind_addr = sel_ptr + 16'h0001;
            `SMI_UPD_PREDEC:  ind_addr = sel_ptr - 16'h0001;
            `SMI_UPD_POSTINC: ind_addr = sel_ptr;
            default:          ind_addr = sel_ptr;
         endcase
      end
   end

   // an indirect load through a window address is not special-cased
   assign read_addr = is_ind ? ind_addr : direct_addr;

   // forward the pending write-back so a back-to-back read sees it
   assign read_data = (rf_we_reg && (rf_waddr_reg == read_addr)) ? rf_wdata_reg : i_rf_rdata;

   assign result = is_shift ? {1'b0, read_data[7:1]} : read_data;
   assign to_acc = is_ind | ~i_dest_sel;

   // relative mode never moves the pointer
   assign step      = op_fire & is_ind & ~i_rel_mode;
   assign step_down = i_update_code[0];

   // software pointer loads
   // a pointer step in the same cycle wins and the software write is lost
   wire        sw_fire;
   wire        sw_ptr0;
   wire        sw_ptr1;
   wire        sw_ctrl;

   assign sw_fire = i_ce & aw_got_reg & w_got_reg & ~bvalid_reg;
   assign sw_ptr0 = sw_fire & (awaddr_reg == `SMI_ADDR_PTR0);
   assign sw_ptr1 = sw_fire & (awaddr_reg == `SMI_ADDR_PTR1);
   assign sw_ctrl = sw_fire & (awaddr_reg == `SMI_ADDR_CTRL);

   smi_ptr u_ptr0
   (
      .i_clock   (i_clock),
      .i_nrst    (i_nrst),
      .i_ce      (i_ce),
      .i_step    (step & ~i_ptr_sel),
      .i_down    (step_down),
      .i_sw_we   (sw_ptr0),
      .i_sw_strb (wstrb_reg[1:0]),
      .i_sw_data (wdata_reg[15:0]),
      .o_ptr     (ptr0)
   );

   smi_ptr u_ptr1
   (
      .i_clock   (i_clock),
      .i_nrst    (i_nrst),
      .i_ce      (i_ce),
      .i_step    (step & i_ptr_sel),
      .i_down    (step_down),
      .i_sw_we   (sw_ptr1),
      .i_sw_strb (wstrb_reg[1:0]),
      .i_sw_data (wdata_reg[15:0]),
      .o_ptr     (ptr1)
   );

   // execution: every operation retires in a single cycle
   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         acc_reg      <= `SMI_ACC_RESET;
         zero_reg     <= 1'b0;
         carry_reg    <= 1'b0;
         rf_we_reg    <= 1'b0;
         rf_waddr_reg <= 16'h0000;
         rf_wdata_reg <= 8'h00;
         count_reg    <= `SMI_COUNT_RESET;
      end
      else if (i_ce)
      begin
         rf_we_reg <= 1'b0;
         if (op_fire)
         begin
            count_reg <= count_reg + 16'h0001;
            // pointer stepping never reaches these flags
            zero_reg  <= (result == 8'h00);
            // carry moves only on a shift
            if (is_shift)
               carry_reg <= read_data[0];
            if (to_acc)
               acc_reg <= result;
            else
            begin
               rf_we_reg    <= 1'b1;
               rf_waddr_reg <= direct_addr;
               rf_wdata_reg <= result;
            end
         end
      end
   end

   // AXI4-Lite write channel: address and data taken in either order
   assign o_s_axi_awready = ~aw_got_reg & ~bvalid_reg;
   assign o_s_axi_wready  = ~w_got_reg & ~bvalid_reg;

   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= `SMI_RESP_OKAY;
         en_reg     <= `SMI_CTRL_RESET;
      end
      else if (i_ce)
      begin
         if (i_s_axi_awvalid && o_s_axi_awready)
         begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= i_s_axi_awaddr;
         end
         if (i_s_axi_wvalid && o_s_axi_wready)
         begin
            w_got_reg <= 1'b1;
            wdata_reg <= i_s_axi_wdata;
            wstrb_reg <= i_s_axi_wstrb;
         end
         if (sw_fire)
         begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            bvalid_reg <= 1'b1;
            if (sw_ctrl)
            begin
               bresp_reg <= `SMI_RESP_OKAY;
               if (wstrb_reg[0])
                  en_reg <= wdata_reg[`SMI_CTRL_EN_BIT];
            end
            else if (sw_ptr0 || sw_ptr1)
               bresp_reg <= `SMI_RESP_OKAY;
            // writes to the read-only registers are accepted and ignored
            else if ((awaddr_reg == `SMI_ADDR_STATUS) || (awaddr_reg == `SMI_ADDR_COUNT))
               bresp_reg <= `SMI_RESP_OKAY;
            else
               bresp_reg <= `SMI_RESP_DECERR;
         end
         else if (bvalid_reg && i_s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   assign o_s_axi_bvalid = bvalid_reg;
   assign o_s_axi_bresp  = bresp_reg;

   // AXI4-Lite read channel
   assign o_s_axi_arready = ~rvalid_reg;

   always @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= `SMI_RESP_OKAY;
      end
      else if (i_ce)
      begin
         if (i_s_axi_arvalid && o_s_axi_arready)
         begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `SMI_RESP_OKAY;
            if (i_s_axi_araddr == `SMI_ADDR_CTRL)
               rdata_reg <= {31'h0000_0000, en_reg};
            else if (i_s_axi_araddr == `SMI_ADDR_STATUS)
               rdata_reg <= {22'h00_0000, carry_reg, zero_reg, acc_reg};
            else if (i_s_axi_araddr == `SMI_ADDR_PTR0)
               rdata_reg <= {16'h0000, ptr0};
            else if (i_s_axi_araddr == `SMI_ADDR_PTR1)
               rdata_reg <= {16'h0000, ptr1};
            else if (i_s_axi_araddr == `SMI_ADDR_COUNT)
               rdata_reg <= {16'h0000, count_reg};
            else
            begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= `SMI_RESP_DECERR;
            end
         end
         else if (rvalid_reg && i_s_axi_rready)
            rvalid_reg <= 1'b0;
      end
   end

   assign o_s_axi_rvalid = rvalid_reg;
   assign o_s_axi_rdata  = rdata_reg;
   assign o_s_axi_rresp  = rresp_reg;

   // outputs
   // read address is combinational for an asynchronous-read register file
   assign o_rf_raddr = read_addr;
   assign o_rf_we    = rf_we_reg;
   assign o_rf_waddr = rf_waddr_reg;
   assign o_rf_wdata = rf_wdata_reg;
   assign o_accum    = acc_reg;
   assign o_zero     = zero_reg;
   assign o_carry    = carry_reg;
   assign o_ptr0     = ptr0;
   assign o_ptr1     = ptr1;

endmodule // smi_exec

/* testbench/smi_exec_monitor.sv */
// concurrent checks on the smi_exec ports
// assumes it is bound into every smi_exec instance
`timescale 1ns/1ps

module smi_mon
(
   input wire        i_clock,
   input wire        i_nrst,
   input wire        i_ce,
   input wire        i_op_valid,
   input wire [1:0]  i_op_sel,
   input wire [6:0]  i_file_addr,
   input wire        i_dest_sel,
   input wire        i_ptr_sel,
   input wire        i_rel_mode,
   input wire [1:0]  i_update_code,
   input wire [5:0]  i_rel_offset,
   input wire        o_op_ready,
   input wire [15:0] o_rf_raddr,
   input wire [7:0]  i_rf_rdata,
   input wire        o_rf_we,
   input wire [15:0] o_rf_waddr,
   input wire [7:0]  o_rf_wdata,
   input wire [7:0]  o_accum,
   input wire        o_zero,
   input wire        o_carry,
   input wire [15:0] o_ptr0
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   wire go = i_ce & o_op_ready & i_op_valid;
   wire sh = go & (i_op_sel == 2'b01);
   wire cp = go & (i_op_sel == 2'b10);
   wire ld = go & (i_op_sel == 2'b11);
   // window addresses 0 and 1 are redirected, so only direct ones here
   wire wb = (sh | cp) & i_dest_sel & (i_file_addr > 7'h01);
   wire l0 = ld & !i_ptr_sel;
   // a pending write-back to the address being read is what the op must see
   wire [7:0] fd = (o_rf_we && (o_rf_waddr == o_rf_raddr)) ? o_rf_wdata : i_rf_rdata;

   shift_carry_a: assert property (sh |=> o_carry == $past(fd[0]))
      else $error("carry not from bit 0");
   shift_acc_a: assert property (sh & !i_dest_sel |=>
      o_accum == {1'b0, $past(fd[7:1])} && o_zero == ($past(fd[7:1]) == 7'h00))
      else $error("shift result wrong");
   copy_acc_a: assert property (cp & !i_dest_sel |=> o_accum == $past(fd))
      else $error("copy result wrong");
   copy_zero_a: assert property (cp |=> o_zero == ($past(fd) == 8'h00))
      else $error("copy zero flag wrong");
   write_data_a: assert property (wb |=>
      o_rf_wdata == ($past(sh) ? {1'b0, $past(fd[7:1])} : $past(fd)))
      else $error("write-back data wrong");
   write_back_a: assert property (wb |=> o_rf_we && o_rf_waddr == {9'h000, $past(i_file_addr)})
      else $error("write-back missing");
   window_redir_a: assert property (cp & (i_file_addr == 7'h00) |-> o_rf_raddr == o_ptr0)
      else $error("window not redirected");
   ind_load_a: assert property (ld |=> o_accum == $past(fd) && !o_rf_we && $stable(o_carry))
      else $error("indirect load wrong");
   preinc_addr_a: assert property (l0 & !i_rel_mode & (i_update_code == 2'b00) |->
      o_rf_raddr == o_ptr0 + 16'h0001)
      else $error("preincrement address wrong");
   rel_addr_a: assert property (l0 & i_rel_mode |->
      o_rf_raddr == o_ptr0 + {{10{i_rel_offset[5]}}, i_rel_offset})
      else $error("relative address wrong");
   ptr_step_a: assert property (l0 & !i_rel_mode |=>
      o_ptr0 == $past(o_ptr0) + ($past(i_update_code[0]) ? 16'hFFFF : 16'h0001))
      else $error("pointer step wrong");

   cover property (wb);
   cover property (l0 & i_rel_mode);
   cover property (cp & (i_file_addr == 7'h00));
endmodule // smi_mon

bind smi_exec smi_mon u_mon (.*);

/* testbench/test_smi_exec.sv */
// self-checking bench for smi_exec
// assumes a behavioural async-read register file beside the block
`timescale 1ns/1ps
`include "smi_regs.vh"

module test_smi_exec;
   logic        i_clock = 0, i_nrst = 0, i_ce = 1, i_op_valid = 0, i_dest_sel = 0;
   logic        i_ptr_sel = 0, i_rel_mode = 0, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0;
   logic        i_s_axi_bready = 0, i_s_axi_arvalid = 0, i_s_axi_rready = 0;
   logic [1:0]  i_op_sel = 0, i_update_code = 0, rs, o_s_axi_bresp, o_s_axi_rresp;
   logic [6:0]  i_file_addr = 0;
   logic [5:0]  i_rel_offset = 0;
   logic [7:0]  i_s_axi_awaddr = 0, i_s_axi_araddr = 0, i_rf_rdata, o_rf_wdata, o_accum, ex, acc;
   logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata, rd;
   logic [3:0]  i_s_axi_wstrb = 4'hF;
   logic [15:0] o_rf_raddr, o_rf_waddr, o_ptr0, o_ptr1, p, ea;
   logic        o_op_ready, o_rf_we, o_zero, o_carry, cy, o_s_axi_awready, o_s_axi_wready;
   logic        o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic [7:0]  mem [0:65535];
   int          error_cnt = 0, cmp_count = 0;

   smi_exec uut (.*);

   assign i_rf_rdata = mem[o_rf_raddr];
   always #50 i_clock = ~i_clock;
   always @(posedge i_clock) if (o_rf_we) mem[o_rf_waddr] <= o_rf_wdata;

   task chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h exp %h", $time, g, e);
      end
   endtask

   task axw(input logic [7:0] a, input logic [31:0] d);
      logic pa, pw;
      pa = 1;
      pw = 1;
      @(posedge i_clock);
      {i_s_axi_awaddr, i_s_axi_wdata} <= {a, d};
      {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
      while (pa | pw)
      begin
         @(negedge i_clock);
         pa = pa & !o_s_axi_awready;
         pw = pw & !o_s_axi_wready;
         @(posedge i_clock);
         {i_s_axi_awvalid, i_s_axi_wvalid} <= {pa, pw};
      end
      while (!o_s_axi_bvalid) @(negedge i_clock);
      rs = o_s_axi_bresp;
      @(posedge i_clock);
      i_s_axi_bready <= 0;
   endtask

   task axr(input logic [7:0] a);
      @(posedge i_clock);
      {i_s_axi_araddr, i_s_axi_arvalid, i_s_axi_rready} <= {a, 2'h3};
      do @(negedge i_clock); while (!o_s_axi_arready);
      @(posedge i_clock);
      i_s_axi_arvalid <= 0;
      do @(negedge i_clock); while (!o_s_axi_rvalid);
      {rd, rs} = {o_s_axi_rdata, o_s_axi_rresp};
      @(posedge i_clock);
      i_s_axi_rready <= 0;
   endtask

   // returns mid-cycle once any write-back has landed in the file
   task op(input logic [1:0] s, input logic [6:0] f, input logic d, ps, rl,
      input logic [1:0] c, input logic [5:0] k);
      @(posedge i_clock);
      {i_op_valid, i_op_sel, i_file_addr, i_dest_sel} <= {1'b1, s, f, d};
      {i_ptr_sel, i_rel_mode, i_update_code, i_rel_offset} <= {ps, rl, c, k};
      @(posedge i_clock);
      i_op_valid <= 0;
      @(posedge i_clock);
      @(negedge i_clock);
   endtask

   task t_sh(input logic [6:0] f, input logic [7:0] v, input logic d);
      mem[f] = v;
      ex = {1'b0, v[7:1]};
      acc = d ? acc : ex;
      cy = v[0];
      op(`SMI_OP_SHIFT, f, d, 0, 0, 0, 0);
      chk(o_accum, acc);
      chk(mem[f], d ? ex : v);
      chk(o_carry, cy);
      chk(o_zero, ex == 0);
   endtask

   task t_cp(input logic [6:0] f, input logic [7:0] v, input logic d);
      mem[f] = v;
      acc = d ? acc : v;
      op(`SMI_OP_COPY, f, d, 0, 0, 0, 0);
      chk(o_accum, acc);
      chk(o_zero, v == 0);
      chk(o_carry, cy);
   endtask

   // write-back followed at once by a read of the same register
   task t_fwd;
      mem[7] = 8'h84;
      acc = 8'h42;
      cy = 0;
      @(posedge i_clock);
      {i_op_valid, i_op_sel, i_file_addr, i_dest_sel} <= {1'b1, `SMI_OP_SHIFT, 7'h07, 1'b1};
      @(posedge i_clock);
      {i_op_sel, i_dest_sel} <= {`SMI_OP_COPY, 1'b0};
      @(posedge i_clock);
      i_op_valid <= 0;
      @(negedge i_clock);
      chk(o_accum, acc);
      chk(mem[7], acc);
      chk(o_carry, cy);
      chk(o_zero, 0);
   endtask

   // a low clock enable drops the offered op and freezes every register
   task t_freeze;
      @(posedge i_clock);
      i_ce <= 0;
      op(`SMI_OP_SHIFT, 5, 0, 0, 0, 0, 0);
      @(posedge i_clock);
      i_ce <= 1;
      @(negedge i_clock);
      chk(o_accum, 8'h9C);
      chk(o_carry, cy);
      chk(o_ptr1, 16'h0000);
   endtask

   task t_rel(input logic ps, input logic [5:0] k, input logic [15:0] pv);
      ea = pv + {{10{k[5]}}, k};
      mem[ea] = 8'h9C;
      op(`SMI_OP_INDIRECT, 0, 0, ps, 1, 0, k);
      chk(o_accum, 8'h9C);
      chk(ps ? o_ptr1 : o_ptr0, pv);
   endtask

   task t_ind;
      for (int c = 0; c < 4; c++)
      begin
         ea = (c == 0) ? p + 1 : (c == 1) ? p - 1 : p;
         mem[ea] = c[7:0];
         op(`SMI_OP_INDIRECT, 0, 0, 0, 0, c[1:0], 0);
         p = c[0] ? p - 16'h0001 : p + 16'h0001;
         chk(o_accum, c);
         chk(o_zero, c == 0);
         chk(o_ptr0, p);
         chk(o_carry, cy);
      end
   endtask

   task complete_run;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'hA5;
      acc = 0;
      cy = 0;
      repeat (12) @(posedge i_clock);
      i_nrst <= 1;
      // ops must be dropped until the enable bit is set
      mem[5] = 8'h81;
      op(`SMI_OP_SHIFT, 5, 0, 0, 0, 0, 0);
      chk(o_accum, 8'h00);
      chk(o_op_ready, 0);
      axr(8'h14);
      chk(rs, `SMI_RESP_DECERR);
      chk(rd, 32'h0000_0000);
      axw(8'h18, 32'h0000_0001);
      chk(rs, `SMI_RESP_DECERR);
      chk(o_op_ready, 0);
      axw(`SMI_ADDR_CTRL, 32'h0000_0001);
      chk(rs, `SMI_RESP_OKAY);
      t_sh(5, 8'h81, 0);
      t_sh(6, 8'h01, 1);
      t_sh(127, 8'h02, 0);
      t_cp(9, 8'h00, 1);
      t_cp(100, 8'h7F, 0);
      t_fwd;
      axw(`SMI_ADDR_PTR0, 32'h0000_1234);
      mem[16'h1234] = 8'h3C;
      acc = 8'h3C;
      op(`SMI_OP_COPY, `SMI_WIN0_ADDR, 0, 0, 0, 0, 0);
      chk(o_accum, acc);
      p = 16'hFFFF;
      axw(`SMI_ADDR_PTR0, {16'h0000, p});
      t_ind;
      axr(`SMI_ADDR_PTR0);
      chk(rd, {16'h0000, p});
      t_rel(0, 6'h20, p);
      t_rel(1, 6'h1F, 16'h0000);
      t_freeze;
      axr(`SMI_ADDR_STATUS);
      chk(rd, {22'h0, cy, 1'b0, 8'h9C});
      axr(`SMI_ADDR_COUNT);
      chk(rd, 32'h0000_000E);
      i_s_axi_wstrb <= 4'h2;
      axw(`SMI_ADDR_PTR1, 32'h0000_AB55);
      i_s_axi_wstrb <= 4'hF;
      chk(rs, `SMI_RESP_OKAY);
      axr(`SMI_ADDR_PTR1);
      chk(rd, 32'h0000_AB00);
      complete_run;
   end

   initial
   begin
      #200_000;
      error_cnt++;
      complete_run;
   end
endmodule // test_smi_exec
